/* File: rtl/ivc_pick_if.sv */
`timescale 1ns/1ns
interface ivc_pick_if;
   import ivc_pkg::*;
   logic [125:0]      cand;
   logic [125:0][3:0] lvl;
   logic              valid;
   logic [6:0]        index;
   logic [3:0]        level;

   modport src (output cand, output lvl, input valid, input index, input level);
   modport res (input cand, input lvl, output valid, output index, output level);
endinterface

/* File: rtl/ivc_pkg.sv */
// Notes on behaviour
// [RULE1] All peripheral, external and trap requests merge into one core request.
// [RULE2] Software gives each maskable source one of seven active levels.
// [RULE3] Up to eight trap sources are handled besides maskable ones.
// [RULE4] Primary vector table sits in program memory from address 000004h.
// [RULE5] Table holds 126 slots: eight trap vectors then 118 interrupt vectors.
// [RULE6] Each slot holds a 24-bit handler address handed to the core.
// [RULE7] One vector per source, slots one word apart; vector 8 at 0x000014.
// [RULE8] Equal level: lower vector wins; vector 0 outranks all.
// [RULE9] 67 maskable sources and five traps are implemented.
// [RULE10] Alternate select bit makes every vector come from the alternate table.
// [RULE11] Alternate table follows primary with same layout; vector 8 at 0x000114.
// [RULE12] Entry and return latency are fixed, whatever source is served.
// [RULE13] Controller takes no part in reset; reset just clears its state.
// [RULE14] Request numbers map in fixed order; requests 15 and 18 never request.
// [RULE15] Each source has a pending flag set by hardware, cleared only by software.
// [RULE16] Each source has a software enable bit gating its request.
// [RULE17] Each source has a three-bit priority field; request 0 in bits 2..0.
// [RULE18] Winner's 7-bit vector number and 4-bit new level are latched, readable.
// [RULE19] Request only if pending, enabled and level above core level; zero never.
// [RULE20] Vector and level stay stable from request until the core acknowledges.
package ivc_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int IVC_NUM_IRQ  = 118;
   localparam int IVC_NUM_TRAP = 8;
   localparam int IVC_NUM_VEC  = 126; // RULE5
   localparam int IVC_NUM_EXT  = 5;
   localparam int IVC_VEC_W    = 7;
   localparam int IVC_LVL_W    = 4;
   localparam int IVC_PRI_W    = 3;
   localparam int IVC_ADDR_W   = 24;
   localparam int IVC_TAB_W    = 8;

   // ---------------------------------------------------------------
   // Table layout
   // ---------------------------------------------------------------
   localparam logic [23:0] IVC_PRI_BASE  = 24'h000004;
   localparam logic [23:0] IVC_ALT_BASE  = 24'h000104;
   localparam logic [23:0] IVC_RST_ADDR  = 24'h000000;
   localparam logic [6:0]  IVC_IRQ_VEC0  = 7'h08;

   // Implemented sources: reserved requests 15, 18, 45, 62, 67 and 72 upward stay dark
   localparam logic [117:0] IVC_IRQ_IMPL  = 118'hf7_bfff_dfff_fffb_7fff; // RULE9
   localparam logic [7:0]   IVC_TRAP_IMPL = 8'h3e; // RULE9

   // External request pins in order: request numbers of external interrupts 0..4
   localparam int IVC_EXT_IRQ [IVC_NUM_EXT] = '{0, 20, 29, 53, 54};

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [23:0] IVC_HANDLER_RST = 24'h000000;
   localparam logic [6:0]  IVC_VEC_RST     = 7'h00;
   localparam logic [3:0]  IVC_LVL_RST     = 4'h0;

   typedef enum logic [2:0] {
      IVC_IDLE  = 3'b001,
      IVC_FETCH = 3'b010,
      IVC_REQ   = 3'b100
   } ivc_state_e;

   function automatic logic [23:0] ivc_slot_addr(input logic alt, input logic [6:0] vec);
      return (alt ? IVC_ALT_BASE : IVC_PRI_BASE) + {16'h0000, vec, 1'b0};
   endfunction

   // Traps sit above every user level; lower trap vector ranks higher
   function automatic logic [3:0] ivc_trap_level(input logic [2:0] idx);
      return 4'hf - {1'b0, idx};
   endfunction

   function automatic logic [117:0] ivc_sticky(input logic [117:0] q,
                                               input logic [117:0] set,
                                               input logic [117:0] clr,
                                               input logic [117:0] impl);
      return ((q & ~clr) | set) & impl;
   endfunction

endpackage

/* File: rtl/ivc_resolver.sv */
`timescale 1ns/1ns
module ivc_resolver
   import ivc_pkg::*;
(
   // Candidates and winner
   ivc_pick_if.res pick
);

   // Scan downward with >= so that on a tie the lower vector takes over
   always_comb begin
      pick.valid = 1'b0;
      pick.index = IVC_VEC_RST;
      pick.level = IVC_LVL_RST;
      for (int i = IVC_NUM_VEC - 1; i >= 0; i--) begin
         if (pick.cand[i] && (!pick.valid || pick.lvl[i] >= pick.level)) begin // RULE8
            pick.valid = 1'b1;
            pick.index = 7'(i);
            pick.level = pick.lvl[i];
         end
      end
   end

endmodule

/* File: rtl/ivc_top.sv */
`timescale 1ns/1ns
module ivc_top
   import ivc_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              reset,
   // Request sources
   input  wire logic [117:0]      periph_req,
   input  wire logic [4:0]        ext_req_pin,
   input  wire logic [7:0]        trap_req,
   // Software control
   input  wire logic [117:0]      sw_clear_flags,
   input  wire logic [7:0]        sw_clear_traps,
   input  wire logic [117:0]      irq_enable,
   input  wire logic [117:0][2:0] source_priority_regs,
   input  wire logic              alt_table_select,
   input  wire logic [3:0]        cpu_level,
   // Vector table load
   input  wire logic              table_wr_en,
   input  wire logic [7:0]        table_wr_index,
   input  wire logic [23:0]       table_wr_data,
   // Core side
   input  wire logic              core_ack,
   output logic                   irq_req,
   output logic      [23:0]       handler_addr,
   output logic      [23:0]       slot_addr,
   // Status
   output logic      [6:0]        latched_vector_index,
   output logic      [3:0]        latched_new_level,
   output logic      [117:0]      pending_flag_regs,
   output logic      [7:0]        trap_flags
);

   // ---------------------------------------------------------------
   // External pins: two-stage synchroniser
   // ---------------------------------------------------------------
   logic [4:0]   ext_s1_q;
   logic [4:0]   ext_s2_q;
   logic [4:0]   ext_s1_d;
   logic [4:0]   ext_s2_d;
   logic [117:0] raw_set;

   always_comb begin
      ext_s1_d = ext_req_pin;
      ext_s2_d = ext_s1_q;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ext_s1_q <= 5'h00;
         ext_s2_q <= 5'h00;
      end else begin
         ext_s1_q <= ext_s1_d;
         ext_s2_q <= ext_s2_d;
      end
   end

   always_comb begin
      raw_set = periph_req;
      for (int e = 0; e < IVC_NUM_EXT; e++) begin
         raw_set[IVC_EXT_IRQ[e]] = raw_set[IVC_EXT_IRQ[e]] | ext_s2_q[e];
      end
   end

   // ---------------------------------------------------------------
   // Pending flags
   // ---------------------------------------------------------------
   // A set in the same cycle as a clear wins, so no edge is lost
   logic [117:0] pend_q;
   logic [117:0] pend_d;
   logic [7:0]   trap_q;
   logic [7:0]   trap_d;
   logic [117:0] trap_wide;

   always_comb begin
      pend_d    = ivc_sticky(pend_q, raw_set, sw_clear_flags, IVC_IRQ_IMPL); // RULE15 RULE14
      trap_wide = ivc_sticky({110'h0, trap_q}, {110'h0, trap_req},
                             {110'h0, sw_clear_traps}, {110'h0, IVC_TRAP_IMPL}); // RULE3
      trap_d    = trap_wide[7:0];
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pend_q <= '0; // RULE13
         trap_q <= '0;
      end else begin
         pend_q <= pend_d;
         trap_q <= trap_d;
      end
   end

   // ---------------------------------------------------------------
   // Candidate build and resolution
   // ---------------------------------------------------------------
   ivc_pick_if pick ();

   always_comb begin
      pick.cand = '0;
      pick.lvl  = '0;
      for (int t = 0; t < IVC_NUM_TRAP; t++) begin
         pick.lvl[t]  = ivc_trap_level(3'(t));
         pick.cand[t] = trap_q[t] && (pick.lvl[t] > cpu_level); // RULE3
      end
      for (int i = 0; i < IVC_NUM_IRQ; i++) begin
         pick.lvl[i + IVC_NUM_TRAP]  = {1'b0, source_priority_regs[i]}; // RULE17 RULE2
         pick.cand[i + IVC_NUM_TRAP] = pend_q[i] && irq_enable[i] // RULE16
                                       && (source_priority_regs[i] != 3'h0)
                                       && ({1'b0, source_priority_regs[i]} > cpu_level); // RULE19
      end
   end

   ivc_resolver u_resolver (
      .pick (pick.res)
   );

   // ---------------------------------------------------------------
   // Vector table
   // ---------------------------------------------------------------
   logic [23:0] mem_rdata;

   ivc_vec_mem u_vec_mem (
      .core_clk (core_clk),
      .reset    (reset),
      .wr_en    (table_wr_en),
      .wr_index (table_wr_index),
      .wr_data  (table_wr_data),
      .rd_index ({alt_table_select, pick.index}), // RULE10
      .rd_data  (mem_rdata)
   );

   // ---------------------------------------------------------------
   // Request sequencer
   // ---------------------------------------------------------------
   // Fixed path idle -> fetch -> request keeps entry latency source independent
   ivc_state_e  state_q;
   ivc_state_e  state_d;
   logic        req_q;
   logic        req_d;
   logic [6:0]  vec_q;
   logic [6:0]  vec_d;
   logic [3:0]  lvl_q;
   logic [3:0]  lvl_d;
   logic        alt_q;
   logic        alt_d;
   logic [23:0] hand_q;
   logic [23:0] hand_d;
   logic [23:0] slot_q;
   logic [23:0] slot_d;

   always_comb begin
      state_d = state_q;
      req_d   = req_q;
      vec_d   = vec_q;
      lvl_d   = lvl_q;
      alt_d   = alt_q;
      hand_d  = hand_q;
      slot_d  = slot_q;
      unique case (state_q)
         IVC_IDLE: begin
            if (pick.valid) begin
               vec_d   = pick.index; // RULE18
               lvl_d   = pick.level;
               alt_d   = alt_table_select;
               slot_d  = ivc_slot_addr(alt_table_select, pick.index); // RULE4 RULE7 RULE11
               state_d = IVC_FETCH;
            end
         end
         IVC_FETCH: begin
            hand_d  = mem_rdata; // RULE6
            req_d   = 1'b1; // RULE1
            state_d = IVC_REQ;
         end
         IVC_REQ: begin
            // Held until the core takes it; the core then raises its own level
            if (core_ack) begin
               req_d   = 1'b0; // RULE20 RULE12
               state_d = IVC_IDLE;
            end
         end
         default: begin
            req_d   = 1'b0;
            state_d = IVC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= IVC_IDLE; // RULE13
         req_q   <= 1'b0;
         vec_q   <= IVC_VEC_RST;
         lvl_q   <= IVC_LVL_RST;
         alt_q   <= 1'b0;
         hand_q  <= IVC_HANDLER_RST;
         slot_q  <= IVC_RST_ADDR;
      end else begin
         state_q <= state_d;
         req_q   <= req_d;
         vec_q   <= vec_d;
         lvl_q   <= lvl_d;
         alt_q   <= alt_d;
         hand_q  <= hand_d;
         slot_q  <= slot_d;
      end
   end

   assign irq_req              = req_q;
   assign handler_addr         = hand_q;
   assign slot_addr            = slot_q;
   assign latched_vector_index = vec_q;
   assign latched_new_level    = lvl_q;
   assign pending_flag_regs    = pend_q;
   assign trap_flags           = trap_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_win_idle;
      state_q == IVC_IDLE && pick.valid;
   endsequence

   sequence s_fetch_then_req;
      state_q == IVC_FETCH ##1 (req_q && state_q == IVC_REQ);
   endsequence

   entry_fixed_a: assert property (s_win_idle |=> s_fetch_then_req) // RULE12
      else $error("entry did not take exactly two cycles");

   return_fixed_a: assert property (req_q && core_ack |=> !req_q && state_q == IVC_IDLE) // RULE12
      else $error("request not dropped one cycle after acknowledge");

   hold_stable_a: assert property (req_q && !core_ack |=> req_q && $stable(vec_q) // RULE20
                                   && $stable(lvl_q) && $stable(hand_q) && $stable(slot_q))
      else $error("vector or level moved before acknowledge");

   reserved_dark_a: assert property (!pend_q[15] && !pend_q[18] && !pend_q[117]) // RULE14
      else $error("reserved request raised a pending flag");

   set_wins_a: assert property (periph_req[3] && sw_clear_flags[3] |=> pend_q[3]) // RULE15
      else $error("set lost against a simultaneous clear");

   flag_clear_a: assert property (pend_q[3] && sw_clear_flags[3] && !periph_req[3]
                                  |=> !pend_q[3]) // RULE15
      else $error("software clear had no effect");

   level_above_a: assert property ($rose(req_q) |-> lvl_q != 4'h0
                                   && lvl_q > $past(cpu_level, 2)) // RULE19
      else $error("request raised without a level above the core");

   slot_layout_a: assert property ($rose(req_q) |-> slot_q == (alt_q ? 24'h000104 : 24'h000004)
                                   + {16'h0000, vec_q, 1'b0}) // RULE7
      else $error("slot address does not match table layout");

   alt_fetch_a: assert property (s_win_idle ##1 state_q == IVC_FETCH
                                 |-> u_vec_mem.rd_q == u_vec_mem.mem[{alt_q, vec_q}]) // RULE10
      else $error("handler fetched from the wrong table");

   trap_first_a: assert property (s_win_idle and (|pick.cand[7:0]) |-> pick.index < 7'h08) // RULE8
      else $error("maskable source beat a pending trap");

   disabled_quiet_a: assert property (!irq_enable[0] |-> !pick.cand[IVC_IRQ_VEC0]) // RULE16
      else $error("disabled source became a candidate");

endmodule

/* File: rtl/ivc_vec_mem.sv */
`timescale 1ns/1ns
module ivc_vec_mem
   import ivc_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Write port
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_index,
   input  wire logic [23:0] wr_data,
   // Read port
   input  wire logic [7:0]  rd_index,
   output logic      [23:0] rd_data
);

   logic [23:0] mem [256];
   logic [23:0] rd_q;
   logic [23:0] rd_d;

   always_comb begin
      rd_d = mem[rd_index];
   end

   // Primary slots in the lower half, alternate in the upper: same layout
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_index] <= wr_data; // RULE11
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         rd_q <= IVC_HANDLER_RST;
      end else begin
         rd_q <= rd_d; // RULE6
      end
   end

   assign rd_data = rd_q;

endmodule

/* File: testbench/ivc_core_model.sv */
`timescale 1ns/1ns
module ivc_core_model
   import ivc_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Controller side
   input  wire logic        irq_req,
   input  wire logic [23:0] handler_addr,
   input  wire logic [6:0]  latched_vector_index,
   input  wire logic [3:0]  latched_new_level,
   input  wire logic [3:0]  ack_delay,
   output logic             core_ack,
   // Observations
   output logic      [23:0] got_handler,
   output logic      [7:0]  got_count,
   output logic             hold_err
);
   // ---------------------------------------------------------------
   // Acknowledge after a chosen wait, watching the offer hold still
   // ---------------------------------------------------------------
   logic [3:0]  wait_q;
   logic [34:0] held_q;
   logic        seen_q;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         core_ack    <= 1'b0;
         got_handler <= 24'h000000;
         got_count   <= 8'h00;
         hold_err    <= 1'b0;
         wait_q      <= 4'h0;
         held_q      <= '0;
         seen_q      <= 1'b0;
      end else if (core_ack) begin
         // Offer is taken at the edge the acknowledge is seen, then released
         if ({handler_addr, latched_vector_index, latched_new_level} !== held_q) begin
            hold_err <= 1'b1;
         end
         core_ack    <= 1'b0;
         got_handler <= handler_addr;
         got_count   <= got_count + 8'h01;
         wait_q      <= 4'h0;
         seen_q      <= 1'b0;
      end else if (irq_req === 1'b1) begin
         if (seen_q && {handler_addr, latched_vector_index, latched_new_level} !== held_q) begin
            hold_err <= 1'b1;
         end
         held_q <= {handler_addr, latched_vector_index, latched_new_level};
         seen_q <= 1'b1;
         if (wait_q == ack_delay) begin
            core_ack <= 1'b1;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule

/* File: testbench/tb_interrupt_vector_controller.sv */
`timescale 1ns/1ns
module tb_interrupt_vector_controller;
   import ivc_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic              core_clk, reset, alt_table_select, table_wr_en, core_ack;
   logic              irq_req, hold_err;
   logic [117:0]      periph_req, sw_clear_flags, irq_enable, pending_flag_regs;
   logic [117:0]      req_v, en_v;
   logic [117:0][2:0] source_priority_regs, pri_v;
   logic [4:0]        ext_req_pin;
   logic [7:0]        trap_req, sw_clear_traps, table_wr_index, trap_flags, got_count, trap_v;
   logic [3:0]        cpu_level, latched_new_level, ack_delay, cpu_v;
   logic [23:0]       table_wr_data, handler_addr, slot_addr, got_handler;
   logic [6:0]        latched_vector_index;
   int                miscompares = 0;
   int                comparisons = 0;
   // Flag edge, take edge, fetch edge: the request shows after the third
   int                first_lat   = 3;

   ivc_top dut (.core_clk(core_clk), .reset(reset), .periph_req(periph_req),
      .ext_req_pin(ext_req_pin), .trap_req(trap_req), .sw_clear_flags(sw_clear_flags),
      .sw_clear_traps(sw_clear_traps), .irq_enable(irq_enable),
      .source_priority_regs(source_priority_regs), .alt_table_select(alt_table_select),
      .cpu_level(cpu_level), .table_wr_en(table_wr_en), .table_wr_index(table_wr_index),
      .table_wr_data(table_wr_data), .core_ack(core_ack), .irq_req(irq_req),
      .handler_addr(handler_addr), .slot_addr(slot_addr),
      .latched_vector_index(latched_vector_index), .latched_new_level(latched_new_level),
      .pending_flag_regs(pending_flag_regs), .trap_flags(trap_flags));

   ivc_core_model core (.core_clk(core_clk), .reset(reset), .irq_req(irq_req),
      .handler_addr(handler_addr), .latched_vector_index(latched_vector_index),
      .latched_new_level(latched_new_level), .ack_delay(ack_delay), .core_ack(core_ack),
      .got_handler(got_handler), .got_count(got_count), .hold_err(hold_err));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Handler contents differ per table and slot so a wrong fetch shows
   function automatic logic [23:0] hv(input logic alt, input logic [6:0] v);
      return 24'h200000 | {8'h00, alt, v, 8'h5c};
   endfunction

   task automatic chk_val(input string what, input logic [117:0] exp, input logic [117:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic close_out;
      if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic apply(input logic alt);
      @(posedge core_clk);
      periph_req           <= req_v;
      irq_enable           <= en_v;
      source_priority_regs <= pri_v;
      trap_req             <= trap_v;
      alt_table_select     <= alt;
      cpu_level            <= cpu_v;
   endtask

   task automatic clear_all;
      @(posedge core_clk);
      sw_clear_flags <= '1;
      sw_clear_traps <= '1;
      periph_req     <= '0;
      trap_req       <= '0;
      req_v = '0;
      trap_v = 8'h00;
      @(posedge core_clk);
      sw_clear_flags <= '0;
      sw_clear_traps <= '0;
   endtask

   task automatic serve(input logic [6:0] vec, input logic [3:0] lvl, input logic alt);
      int          lat;
      logic [7:0]  cnt0;
      logic [23:0] base;
      cnt0 = got_count;
      base = alt ? IVC_ALT_BASE : IVC_PRI_BASE;
      apply(alt);
      lat = 0;
      #1;
      while (irq_req !== 1'b1 && lat < 40) begin
         @(posedge core_clk);
         #1;
         lat++;
      end
      chk_val("entry latency", first_lat, lat);
      chk_bit("irq_req", 1'b1, irq_req);
      chk_val("vector index", vec, latched_vector_index);
      chk_val("new level", lvl, latched_new_level);
      chk_val("slot address", base + {16'h0000, vec, 1'b0}, slot_addr);
      chk_val("handler offered", hv(alt, vec), handler_addr);
      clear_all;
      lat = 0;
      while (got_count === cnt0 && lat < 40) begin
         @(posedge core_clk);
         #1;
         lat++;
      end
      chk_val("handler taken", hv(alt, vec), got_handler);
      chk_bit("offer held", 1'b0, hold_err);
      repeat (2) @(posedge core_clk);
      #1;
      chk_bit("irq_req after ack", 1'b0, irq_req);
   endtask

   task automatic quiet;
      apply(1'b0);
      repeat (8) @(posedge core_clk);
      #1;
      chk_bit("irq_req quiet", 1'b0, irq_req);
      chk_val("trap flags", 8'h00, trap_flags);
      clear_all;
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and tests
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Whole run is well under a thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      close_out;
   end

   initial begin
      reset = 1'b1;
      {periph_req, sw_clear_flags, irq_enable, req_v, en_v} = '0;
      {source_priority_regs, pri_v} = '0;
      {ext_req_pin, trap_req, sw_clear_traps, trap_v, table_wr_index} = '0;
      {alt_table_select, table_wr_en, table_wr_data, cpu_level, cpu_v, ack_delay} = '0;
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      #1;
      chk_bit("irq_req at reset", 1'b0, irq_req);
      chk_val("flags at reset", '0, pending_flag_regs);
      for (int i = 0; i < 256; i++) begin
         if (i % 128 < IVC_NUM_VEC) begin
            @(posedge core_clk);
            table_wr_en    <= 1'b1;
            table_wr_index <= i[7:0];
            table_wr_data  <= hv(i[7], i[6:0]);
         end
      end
      @(posedge core_clk);
      table_wr_en <= 1'b0;
      req_v[3] = 1'b1;
      req_v[15] = 1'b1;
      req_v[18] = 1'b1;
      apply(1'b0);
      ext_req_pin <= 5'h02;
      req_v = '0;
      apply(1'b0);
      repeat (5) @(posedge core_clk);
      #1;
      chk_val("flags set", (118'h1 << 3) | (118'h1 << 20), pending_flag_regs);
      @(posedge core_clk);
      ext_req_pin <= 5'h00;
      repeat (4) @(posedge core_clk);
      clear_all;
      @(posedge core_clk);
      #1;
      chk_val("flags cleared", '0, pending_flag_regs);
      @(posedge core_clk);
      periph_req[3]     <= 1'b1;
      sw_clear_flags[3] <= 1'b1;
      @(posedge core_clk);
      periph_req[3]     <= 1'b0;
      sw_clear_flags[3] <= 1'b0;
      #1;
      chk_val("set beats clear", 118'h8, pending_flag_regs);
      en_v = '1;
      req_v[0] = 1'b1;
      pri_v[0] = 3'h3;
      serve(7'h08, 4'h3, 1'b0);
      chk_val("primary slot of vector 8", 24'h000014, slot_addr);
      @(posedge core_clk);
      ack_delay <= 4'h5;
      req_v[0] = 1'b1;
      serve(7'h08, 4'h3, 1'b1);
      chk_val("alternate slot of vector 8", 24'h000114, slot_addr);
      req_v[3] = 1'b1;
      req_v[5] = 1'b1;
      pri_v[3] = 3'h4;
      pri_v[5] = 3'h4;
      serve(7'h0b, 4'h4, 1'b0);
      req_v[3] = 1'b1;
      req_v[5] = 1'b1;
      pri_v[3] = 3'h2;
      pri_v[5] = 3'h6;
      serve(7'h0d, 4'h6, 1'b0);
      req_v[0] = 1'b1;
      pri_v[0] = 3'h7;
      trap_v[1] = 1'b1;
      serve(7'h01, 4'he, 1'b0);
      req_v[4] = 1'b1;
      pri_v[4] = 3'h2;
      cpu_v = 4'h2;
      quiet();
      req_v[4] = 1'b1;
      pri_v[4] = 3'h0;
      cpu_v = 4'h0;
      quiet();
      req_v[4] = 1'b1;
      pri_v[4] = 3'h5;
      en_v[4] = 1'b0;
      quiet();
      trap_v = 8'hc1;
      quiet();
      req_v[4] = 1'b1;
      en_v[4] = 1'b1;
      cpu_v = 4'h4;
      serve(7'h0c, 4'h5, 1'b0);
      req_v[3] = 1'b1;
      apply(1'b0);
      repeat (3) @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      chk_val("flags after reset", '0, pending_flag_regs);
      chk_bit("irq_req after reset", 1'b0, irq_req);
      close_out;
   end
endmodule
